// *** common/chc_pkg.sv ***
// Shared constants for the cache hierarchy control block.
// Assumes one clock; used by every design file here.
package chc_pkg;
   // Line geometry.
   localparam int L1_LINE_BYTES   = 64;
   localparam int L2_LINE_BYTES   = 256;
   localparam int L2_SUBLINES     = L2_LINE_BYTES / L1_LINE_BYTES;
   localparam int L1_KBYTES       = 128;
   localparam int L1_WAYS         = 2;
   localparam int L2_MAX_KBYTES   = 6144;
   localparam int L2_MAX_WAYS     = 12;
   // Alternate space identifiers.
   localparam logic [7:0] SPACE_BYPASS    = 8'h15;
   localparam logic [7:0] SPACE_BYPASS_LE = 8'h1D;
   localparam logic [7:0] SPACE_IFLUSH    = 8'h67;
   localparam logic [7:0] SPACE_L2CTRL    = 8'h6A;
   localparam logic [7:0] SPACE_TAGPROBE  = 8'h6B;
   localparam logic [7:0] SPACE_TAGRES    = 8'h6C;
   localparam logic [7:0] SPACE_LINEINV   = 8'h74;
   // Control register fields.
   localparam int BIT_ERR_STICKY  = 24;
   localparam int BIT_L2_FLUSH    = 0;
   localparam logic [63:0] L2CTRL_RESET = 64'h0;
   // Fault codes.
   localparam logic [7:0] FT_INVALID_SPACE = 8'h08;
   // Three bit line state: valid, exclusive, modified.
   localparam int ST_VALID = 2;
   localparam int ST_EXCL  = 1;
   localparam int ST_MOD   = 0;
   localparam logic [2:0] ST_S = 3'h4;
   localparam logic [2:0] ST_E = 3'h6;
   localparam logic [2:0] ST_O = 3'h5;
   localparam logic [2:0] ST_M = 3'h7;
   // Tag result bank.
   localparam int TAG_REGS = 7;
   localparam int TAG_W    = 64;
   // Opcode classes of an alternate access.
   typedef enum logic [2:0] {
      OP_LDDA, OP_LDXA, OP_LDDFA, OP_STDA, OP_STXA, OP_STDFA, OP_OTHER
   } chc_op_t;
endpackage

// *** hdl/chc_bypass.sv ***
`timescale 1ns/1ps
// Cacheability decisions for fetches and data.
// Assumes same-clock inputs; purely combinational.
module chc_bypass
   import chc_pkg::*;
(
   // Fetch side
   input  wire logic       red_state_flag,
   input  wire logic       icache_enable_bit,
   input  wire logic       force_instr_cacheable,
   input  wire logic       fetch_page_cacheable,
   output logic            fetch_l1_cacheable,
   output logic            fetch_l2_cacheable,
   // Data side
   input  wire logic [7:0] data_space,
   input  wire logic       dcache_enable_bit,
   input  wire logic       data_page_cacheable,
   output logic            data_l1_cacheable,
   output logic            data_l2_cacheable
);
   logic fetch_nc;

   // The force bit overrides the first level only.
   always_comb begin
      fetch_nc           = red_state_flag | ~icache_enable_bit | ~fetch_page_cacheable;
      fetch_l1_cacheable = ~fetch_nc | force_instr_cacheable;
      fetch_l2_cacheable = ~fetch_nc;
   end

   // Data ignores the force bit entirely.
   always_comb begin
      data_l1_cacheable = !(data_space == SPACE_BYPASS || data_space == SPACE_BYPASS_LE)
                          && dcache_enable_bit && data_page_cacheable;
      data_l2_cacheable = data_l1_cacheable;
   end
endmodule

// *** hdl/chc_coherency.sv ***
`timescale 1ns/1ps
// Coherency between level-two line state and level-one copies.
// Assumes the arrays report evictions and stores; one clock.
module chc_coherency
   import chc_pkg::*;
#(
   parameter int PA_W = 43
)
(
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            rstn,
   // Events from the arrays
   input  wire logic            l2_evict,
   input  wire logic [PA_W-1:0] l2_evict_pa,
   input  wire logic            istore,
   input  wire logic [PA_W-1:0] istore_pa,
   input  wire logic            l2_fill,
   input  wire logic [2:0]      l2_fill_state,
   input  wire logic [PA_W-1:0] l2_fill_pa,
   // Commands to the first-level caches
   output logic                 l1i_inv,
   output logic                 l1d_flush_inv,
   output logic [PA_W-1:0]      l1_inv_pa,
   output logic                 l1d_excl_mod,
   output logic                 l1d_sat_valid,
   output logic                 l1i_allow
);
   typedef struct packed {
      logic            iinv;
      logic            dinv;
      logic [PA_W-1:0] pa;
      logic            dm;
      logic            store_ownership_tag;
      logic            iok;
   } chc_coh_t;

   chc_coh_t s_reg;
   chc_coh_t s_next;

   function automatic logic is_mod_excl(input logic [2:0] st);
      return st == ST_M;
   endfunction

   // Eviction beats the store-invalidate since it covers both caches.
   always_comb begin
      s_next      = s_reg;
      s_next.iinv = 1'b0;
      s_next.dinv = 1'b0;
      if (l2_evict) begin
         s_next.iinv = 1'b1;
         s_next.dinv = 1'b1;
         s_next.pa   = l2_evict_pa;
      end else if (istore) begin
         s_next.iinv = 1'b1;
         s_next.pa   = istore_pa;
      end else if (l2_fill) begin
         s_next.pa   = l2_fill_pa;
         s_next.dm   = is_mod_excl(l2_fill_state);
         s_next.store_ownership_tag  = is_mod_excl(l2_fill_state);
         s_next.iok  = l2_fill_state[ST_VALID] & ~is_mod_excl(l2_fill_state);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign l1i_inv       = s_reg.iinv;
   assign l1d_flush_inv = s_reg.dinv;
   assign l1_inv_pa     = s_reg.pa;
   assign l1d_excl_mod  = s_reg.dm;
   assign l1d_sat_valid = s_reg.store_ownership_tag;
   assign l1i_allow     = s_reg.iok;
endmodule

// *** hdl/chc_top.sv ***
`timescale 1ns/1ps
// Cache hierarchy control: cache commands, control register, tag capture,
// cacheability and coherency between the levels.
// Assumes one committed, non-speculative access at a time.
//
// How it works
// - Lines: 64 bytes, level two 256.
// - Level two includes level one.
// - Level-two eviction drops level-one copies.
// - Code stores invalidate the code line, except in a cycle with an eviction.
// - Code cache: 128 KB, two-way, VIPT.
// - Fetch bypass: red, cache off, page uncached.
// - Force bit makes fetches level-one cacheable only.
// - Data cache: writeback, 128 KB, two-way.
// - Data bypass: bypass space, cache off, page uncached.
// - Level two: writeback, 6 MB, 12 ways max.
// - Noncacheable skips level two; no force bit.
// - State bits: valid, exclusive, modified.
// - Modified exclusive lines: data modified, no code copy.
// - Other opcodes fault, type 08.
// - Address bits 2:0 nonzero: misaligned.
// - Don't-care bits read zero.
// - Ordered, non-speculative, big-endian.
// - Space 67 write flushes code cache.
// - Bit 24 sticky on errors; privileged write of one clears.
// - Bit 0 write flushes level two, stalls.
// - Space 6B read returns zero, captures tags.
// - Space 74 write invalidates; read faults.
module chc_top
   import chc_pkg::*;
#(
   parameter int PA_W  = 43,
   parameter int IDX_W = 13
)
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rstn,
   // Alternate-space access from the pipeline
   input  wire logic             acc_valid,
   input  wire logic             acc_write,
   input  wire logic             acc_priv,
   input  wire chc_op_t          acc_op,
   input  wire logic [7:0]       acc_space,
   input  wire logic [63:0]      acc_va,
   input  wire logic [63:0]      acc_wdata,
   input  wire logic             little_endian_default,
   output logic                  acc_done,
   output logic [63:0]           acc_rdata,
   output logic                  fault_data_access,
   output logic                  fault_misaligned,
   output logic [7:0]            data_fault_type,
   output logic                  exec_stall,
   // Error exception events
   input  wire logic             err_instr_access,
   input  wire logic             err_data_access,
   input  wire logic             err_async_data,
   // Cache array control
   output logic                  icache_flush_all,
   output logic                  l2_flush_req,
   input  wire logic             l2_flush_done,
   output logic                  tag_probe_req,
   output logic [IDX_W-1:0]      tag_probe_index,
   input  wire logic             tag_probe_valid,
   input  wire logic [TAG_W-1:0] tag_probe_data [TAG_REGS],
   output logic                  line_inv_req,
   output logic [PA_W-1:0]       line_inv_pa,
   // Cacheability
   input  wire logic             red_state_flag,
   input  wire logic             icache_enable_bit,
   input  wire logic             dcache_enable_bit,
   input  wire logic             force_instr_cacheable,
   input  wire logic             fetch_page_cacheable,
   input  wire logic [7:0]       data_space,
   input  wire logic             data_page_cacheable,
   output logic                  fetch_l1_cacheable,
   output logic                  fetch_l2_cacheable,
   output logic                  data_l1_cacheable,
   output logic                  data_l2_cacheable,
   // Coherency events
   input  wire logic             l2_evict,
   input  wire logic [PA_W-1:0]  l2_evict_pa,
   input  wire logic             istore,
   input  wire logic [PA_W-1:0]  istore_pa,
   input  wire logic             l2_fill,
   input  wire logic [2:0]       l2_fill_state,
   input  wire logic [PA_W-1:0]  l2_fill_pa,
   output logic                  l1i_inv,
   output logic                  l1d_flush_inv,
   output logic [PA_W-1:0]       l1_inv_pa,
   output logic                  l1d_excl_mod,
   output logic                  l1d_sat_valid,
   output logic                  l1i_allow
);
   typedef enum logic [1:0] {S_IDLE, S_FLUSH, S_PROBE} chc_state_t;

   typedef struct packed {
      chc_state_t              st;
      logic                    sticky;
      logic                    done;
      logic [63:0]             rdata;
      logic                    fda;
      logic                    fma;
      logic [7:0]              ft;
      logic                    iflush;
      logic                    l2f;
      logic                    probe;
      logic [IDX_W-1:0]        pidx;
      logic                    linv;
      logic [PA_W-1:0]         lpa;
      logic [TAG_REGS*TAG_W-1:0] tags;
   } chc_top_t;

   chc_top_t r_reg;
   chc_top_t r_next;
   logic     legal_op;
   logic     aligned;
   logic     sel_tag_ok;
   logic [3:0] tag_sel;

   // Six doubleword opcodes are legal.
   function automatic logic op_ok(input chc_op_t op);
      return op != OP_OTHER;
   endfunction

   // Results stay big-endian, so no swap.
   function automatic logic [63:0] be_data(input logic [63:0] d);
      return d;
   endfunction

   always_comb begin
      legal_op   = op_ok(acc_op);
      aligned    = acc_va[2:0] == 3'h0;
      tag_sel    = acc_va[6:3];
      sel_tag_ok = tag_sel < 4'(TAG_REGS);
   end

   // Flush and probe states hold off the next access, keeping order.
   always_comb begin
      r_next        = r_reg;
      r_next.done   = 1'b0;
      r_next.fda    = 1'b0;
      r_next.fma    = 1'b0;
      r_next.iflush = 1'b0;
      r_next.linv   = 1'b0;
      r_next.probe  = 1'b0;
      // A new error wins over a same-cycle clear.
      if (acc_valid && r_reg.st == S_IDLE && acc_write && acc_space == SPACE_L2CTRL
          && legal_op && aligned && acc_priv && acc_wdata[BIT_ERR_STICKY]) begin
         r_next.sticky = 1'b0;
      end
      if (err_instr_access || err_data_access || err_async_data) begin
         r_next.sticky = 1'b1;
      end
      case (r_reg.st)
         S_IDLE: begin
            if (acc_valid) begin
               r_next.done  = 1'b1;
               r_next.rdata = 64'h0;
               if (!legal_op) begin
                  r_next.fda = 1'b1;
                  r_next.ft  = FT_INVALID_SPACE;
               end else if (!aligned) begin
                  r_next.fma = 1'b1;
               end else begin
                  case (acc_space)
                     SPACE_IFLUSH: begin
                        if (acc_write) begin
                           r_next.iflush = 1'b1;
                        end else begin
                           r_next.fda = 1'b1;
                           r_next.ft  = FT_INVALID_SPACE;
                        end
                     end
                     SPACE_L2CTRL: begin
                        if (acc_write) begin
                           // Bits other than 0 and 24 are discarded; a zero in bit 0 is ignored.
                           if (acc_wdata[BIT_L2_FLUSH]) begin
                              r_next.l2f  = 1'b1;
                              r_next.done = 1'b0;
                              r_next.st   = S_FLUSH;
                           end
                        end else begin
                           r_next.rdata[BIT_ERR_STICKY] = r_reg.sticky;
                        end
                     end
                     SPACE_TAGPROBE: begin
                        if (!acc_write) begin
                           r_next.probe = 1'b1;
                           r_next.pidx  = acc_va[18:6];
                           r_next.done  = 1'b0;
                           r_next.st    = S_PROBE;
                        end else begin
                           r_next.fda = 1'b1;
                           r_next.ft  = FT_INVALID_SPACE;
                        end
                     end
                     SPACE_TAGRES: begin
                        if (!acc_write && sel_tag_ok) begin
                           r_next.rdata = be_data(r_reg.tags[tag_sel*TAG_W +: TAG_W]);
                        end else if (acc_write) begin
                           r_next.fda = 1'b1;
                           r_next.ft  = FT_INVALID_SPACE;
                        end
                     end
                     SPACE_LINEINV: begin
                        if (acc_write) begin
                           r_next.linv = 1'b1;
                           r_next.lpa  = acc_va[PA_W-1:0];
                        end else begin
                           r_next.fda = 1'b1;
                           r_next.ft  = FT_INVALID_SPACE;
                        end
                     end
                     default: begin
                        r_next.fda = 1'b1;
                        r_next.ft  = FT_INVALID_SPACE;
                     end
                  endcase
               end
            end
         end
         S_FLUSH: begin
            if (l2_flush_done) begin
               r_next.l2f  = 1'b0;
               r_next.done = 1'b1;
               r_next.st   = S_IDLE;
            end
         end
         S_PROBE: begin
            if (tag_probe_valid) begin
               for (int i = 0; i < TAG_REGS; i++) begin
                  r_next.tags[i*TAG_W +: TAG_W] = tag_probe_data[i];
               end
               r_next.rdata = 64'h0;
               r_next.done  = 1'b1;
               r_next.st    = S_IDLE;
            end
         end
         default: begin
            r_next.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r_reg        <= '0;
         r_reg.sticky <= L2CTRL_RESET[BIT_ERR_STICKY];
      end else begin
         r_reg <= r_next;
      end
   end

   // Endian default ignored: always big-endian.
   assign acc_done          = r_reg.done;
   assign acc_rdata         = r_reg.rdata;
   assign fault_data_access = r_reg.fda;
   assign fault_misaligned  = r_reg.fma;
   assign data_fault_type   = r_reg.ft;
   assign exec_stall        = r_reg.st == S_FLUSH;
   assign icache_flush_all  = r_reg.iflush;
   assign l2_flush_req      = r_reg.l2f;
   assign tag_probe_req     = r_reg.probe;
   assign tag_probe_index   = r_reg.pidx;
   assign line_inv_req      = r_reg.linv;
   assign line_inv_pa       = r_reg.lpa;

   chc_bypass u_bypass (
      .red_state_flag        (red_state_flag),
      .icache_enable_bit     (icache_enable_bit),
      .force_instr_cacheable (force_instr_cacheable),
      .fetch_page_cacheable  (fetch_page_cacheable),
      .fetch_l1_cacheable    (fetch_l1_cacheable),
      .fetch_l2_cacheable    (fetch_l2_cacheable),
      .data_space            (data_space),
      .dcache_enable_bit     (dcache_enable_bit),
      .data_page_cacheable   (data_page_cacheable),
      .data_l1_cacheable     (data_l1_cacheable),
      .data_l2_cacheable     (data_l2_cacheable)
   );

   chc_coherency #(.PA_W(PA_W)) u_coh (
      .clock         (clock),
      .rstn          (rstn),
      .l2_evict      (l2_evict),
      .l2_evict_pa   (l2_evict_pa),
      .istore        (istore),
      .istore_pa     (istore_pa),
      .l2_fill       (l2_fill),
      .l2_fill_state (l2_fill_state),
      .l2_fill_pa    (l2_fill_pa),
      .l1i_inv       (l1i_inv),
      .l1d_flush_inv (l1d_flush_inv),
      .l1_inv_pa     (l1_inv_pa),
      .l1d_excl_mod  (l1d_excl_mod),
      .l1d_sat_valid (l1d_sat_valid),
      .l1i_allow     (l1i_allow)
   );
endmodule

// *** test/chc_props.sv ***
// Port checks for the cache hierarchy control block.
// Assumes a bind into chc_top; one clock, async low reset.
`timescale 1ns/1ps
module chc_props
   import chc_pkg::*;
#(
   parameter int PA_W  = 43,
   parameter int IDX_W = 13
)
(
   // Clock, reset and access request
   input wire logic             clock, rstn, acc_write,
   input wire logic [7:0]       acc_space, data_space, data_fault_type,
   input wire logic [63:0]      acc_va, acc_wdata,
   // Answers and array commands
   input wire logic             acc_done, fault_data_access, fault_misaligned, exec_stall,
   input wire logic             icache_flush_all, l2_flush_req, tag_probe_req, line_inv_req,
   input wire logic [IDX_W-1:0] tag_probe_index,
   input wire logic [PA_W-1:0]  line_inv_pa, l2_evict_pa, l1_inv_pa,
   // Cacheability and coherency
   input wire logic             red_state_flag, icache_enable_bit, force_instr_cacheable,
   input wire logic             fetch_page_cacheable, dcache_enable_bit, data_page_cacheable,
   input wire logic             fetch_l1_cacheable, fetch_l2_cacheable, data_l1_cacheable,
   input wire logic             l2_evict, l1i_inv, l1d_flush_inv
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Any of three causes blocks fetch caching.
   logic fetch_nc;
   assign fetch_nc = red_state_flag | !icache_enable_bit | !fetch_page_cacheable;
   // Combinational decisions match on every edge.
   fetch_l1_a: assert property (fetch_l1_cacheable == (force_instr_cacheable | !fetch_nc))
      else $error("fetch l1 wrong");
   fetch_l2_a: assert property (fetch_l2_cacheable == !fetch_nc)
      else $error("fetch l2 wrong");
   data_l1_a: assert property (data_l1_cacheable == (dcache_enable_bit && data_page_cacheable
      && data_space != SPACE_BYPASS && data_space != SPACE_BYPASS_LE))
      else $error("data l1 wrong");
   // Commands trace back to their access.
   iflush_cause_a: assert property (icache_flush_all |-> $past(acc_write && acc_space == SPACE_IFLUSH))
      else $error("iflush cause");
   inv_addr_a: assert property (line_inv_req |-> $past(acc_write && acc_space == SPACE_LINEINV)
      && line_inv_pa == $past(acc_va[PA_W-1:0])) else $error("inv addr");
   probe_index_a: assert property (tag_probe_req |-> tag_probe_index == $past(acc_va[18:6]))
      else $error("probe idx");
   fault_code_a: assert property (fault_data_access |-> acc_done && data_fault_type == 8'h08)
      else $error("fault code");
   misalign_a: assert property (fault_misaligned |-> $past(acc_va[2:0]) != 3'h0 && !fault_data_access)
      else $error("misalign");
   flush_stall_a: assert property ($rose(l2_flush_req) |-> exec_stall
      && $past(acc_write && acc_space == SPACE_L2CTRL && acc_wdata[0])) else $error("flush start wrong");
   evict_inv_a: assert property (l2_evict |=> l1i_inv && l1d_flush_inv && l1_inv_pa == $past(l2_evict_pa))
      else $error("evict inv");
   cover property (fault_data_access);
   cover property ($fell(exec_stall));
   cover property (tag_probe_req);
endmodule

// *** test/chc_array_model.sv ***
// Cache array model: answers full flushes and tag probes.
// Assumes the block's clock; lat sets the answer delay.
`timescale 1ns/1ps
module chc_array_model
   import chc_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Requests and answers
   input  wire logic        l2_flush_req,
   input  wire logic        tag_probe_req,
   input  wire logic [12:0] tag_probe_index,
   input  wire logic [3:0]  lat,
   output logic             l2_flush_done,
   output logic             tag_probe_valid,
   output logic [TAG_W-1:0] tag_probe_data [TAG_REGS]
);
   logic        busy_reg, probe_reg;
   logic [3:0]  cnt_reg;
   logic [12:0] idx_reg;
   // One job at a time; answer pulses lat+1 cycles after the job is taken.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         {busy_reg, probe_reg, l2_flush_done, tag_probe_valid, cnt_reg, idx_reg} <= '0;
      end else begin
         l2_flush_done <= 1'b0;
         tag_probe_valid <= 1'b0;
         if (!busy_reg && (tag_probe_req || (l2_flush_req && !l2_flush_done))) begin
            {busy_reg, probe_reg, cnt_reg, idx_reg} <= {1'b1, tag_probe_req, lat, tag_probe_index};
         end else if (busy_reg && cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
         end else if (busy_reg) begin
            busy_reg <= 1'b0;
            l2_flush_done <= !probe_reg;
            tag_probe_valid <= probe_reg;
         end
      end
   end
   // Tag words carry the index; inverted outside the answer.
   always_comb begin
      for (int n = 0; n < TAG_REGS; n++) begin
         tag_probe_data[n] = {8'(8'hA0 + n), 43'h0, idx_reg} ^ {64{!tag_probe_valid}};
      end
   end
endmodule

// *** test/cache_hierarchy_control_tb.sv ***
// Self-checking bench for chc_top and the array model.
// Assumes a 50 MHz clock; the access driver queues expected answers.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cache_hierarchy_control_tb;
   import chc_pkg::*;
   localparam int PA_W = 43, IDX_W = 13;
   localparam logic [66:0] NONE = 67'h0, FDA = {3'h2, 64'h0}, FMIS = {3'h1, 64'h0};
   localparam logic [66:0] RD0 = {3'h4, 64'h0}, STK = {3'h4, 64'h1000000};
   logic clock = 0, rstn = 0, acc_valid = 0, acc_write = 0, acc_priv = 1, little_endian_default = 0;
   logic err_instr_access = 0, err_data_access = 0, err_async_data = 0, red_state_flag = 0;
   logic icache_enable_bit = 0, dcache_enable_bit = 0, force_instr_cacheable = 0;
   logic fetch_page_cacheable = 0, data_page_cacheable = 0, l2_evict = 0, istore = 0, l2_fill = 0;
   chc_op_t acc_op = OP_LDXA;
   logic [7:0] acc_space = 0, data_space = 0, data_fault_type;
   logic [63:0] acc_va = 0, acc_wdata = 0, acc_rdata;
   logic [2:0] l2_fill_state = 0;
   logic [3:0] lat = 2;
   logic [PA_W-1:0] l2_evict_pa = 0, istore_pa = 0, l2_fill_pa = 0, line_inv_pa, l1_inv_pa;
   logic acc_done, fault_data_access, fault_misaligned, exec_stall, icache_flush_all;
   logic l2_flush_req, l2_flush_done, tag_probe_req, tag_probe_valid, line_inv_req;
   logic fetch_l1_cacheable, fetch_l2_cacheable, data_l1_cacheable, data_l2_cacheable;
   logic l1i_inv, l1d_flush_inv, l1d_excl_mod, l1d_sat_valid, l1i_allow;
   logic [IDX_W-1:0] tag_probe_index;
   logic [TAG_W-1:0] tag_probe_data [TAG_REGS];
   logic [66:0] exp_q [$];
   int n_errors = 0, samples_checked = 0, stall_cnt = 0, fl_cnt = 0;
   chc_top #(.PA_W(PA_W), .IDX_W(IDX_W)) DUT (.*);
   chc_array_model u_arr (.*);
   // Free-running 50 MHz clock.
   initial forever #10 clock = ~clock;
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One access, then a bounded wait for done.
   task automatic acc(input logic w, input chc_op_t op, input logic [7:0] sp,
                      input logic [63:0] va, input logic [63:0] wd, input logic [66:0] e);
      int i;
      exp_q.push_back(e);
      {acc_valid, acc_write, acc_space, acc_va, acc_wdata} <= {1'b1, w, sp, va, wd};
      acc_op <= op;
      little_endian_default <= 1'($urandom);
      @(posedge clock);
      acc_valid <= 1'b0;
      for (i = 0; i < 60 && acc_done !== 1'b1; i++) @(posedge clock);
      if (i == 60) begin n_errors++; print_verdict(); end
   endtask
   // Each done takes the oldest note; non-faulting reads compare data.
   always @(posedge clock) begin
      logic [66:0] e;
      if (exec_stall === 1'b1) stall_cnt++;
      if (icache_flush_all === 1'b1) fl_cnt++;
      if (acc_done === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
         `CHK(fault_data_access, e[65])
         `CHK(fault_misaligned, e[64])
         if (e[66]) `CHK(acc_rdata, e[63:0])
      end
   end
   // Reset, then one block per behaviour.
   initial begin
      logic [63:0] va;
      logic fc;
      void'($urandom(32'h768A5C7B));
      for (int q = 0; q < 2; q++) begin
         rstn <= 1'b0;
         repeat (10) @(posedge clock);
         rstn <= 1'b1;
         @(posedge clock);
         `CHK({acc_done, l2_flush_req, exec_stall, tag_probe_req, line_inv_req}, 5'h0)
         acc(0, OP_LDXA, SPACE_L2CTRL, 0, 0, RD0);
         err_data_access <= (q == 0);
         @(posedge clock);
         err_data_access <= 1'b0;
      end
      $display("reset test done");
      for (int k = 0; k < 64; k++) begin
         {red_state_flag, icache_enable_bit, force_instr_cacheable, fetch_page_cacheable,
          dcache_enable_bit, data_page_cacheable} <= 6'($urandom);
         va = $urandom % 3;
         data_space <= (va == 0) ? SPACE_BYPASS : (va == 1) ? SPACE_BYPASS_LE : 8'($urandom);
         @(negedge clock);
         fc = !red_state_flag & icache_enable_bit & fetch_page_cacheable;
         `CHK(fetch_l1_cacheable, force_instr_cacheable | fc)
         `CHK(fetch_l2_cacheable, fc)
         fc = dcache_enable_bit && data_page_cacheable && data_space != SPACE_BYPASS
              && data_space != SPACE_BYPASS_LE;
         `CHK({data_l1_cacheable, data_l2_cacheable}, {fc, fc})
         @(posedge clock);
      end
      $display("cacheability test done");
      for (int k = 0; k < 6; k++) begin
         if (k >= OP_STDA) acc(1, chc_op_t'(k), SPACE_IFLUSH, 64'($urandom) << 3, 0, NONE);
         else acc(0, chc_op_t'(k), SPACE_L2CTRL, 0, 0, RD0);
      end
      acc(1, OP_OTHER, SPACE_IFLUSH, 64'h8, 0, FDA);
      acc(1, OP_OTHER, SPACE_IFLUSH, 64'h5, 0, FDA);
      acc(1, OP_STXA, SPACE_IFLUSH, 64'h4, 0, FMIS);
      `CHK(fl_cnt, 3)
      acc(0, OP_LDXA, SPACE_LINEINV, 0, 0, FDA);
      acc(1, OP_STXA, SPACE_TAGPROBE, 0, 0, FDA);
      acc(1, OP_STDA, 8'h40, 0, 0, FDA);
      acc(1, OP_STXA, SPACE_LINEINV, 64'({$urandom, $urandom}) & 64'h7FF_FFFF_FFC0, 0, NONE);
      $display("opcode and space test done");
      for (int k = 0; k < 3; k++) begin
         {err_async_data, err_data_access, err_instr_access} <= 3'h1 << k;
         @(posedge clock);
         {err_async_data, err_data_access, err_instr_access} <= 3'h0;
         @(posedge clock);
         acc(0, OP_LDXA, SPACE_L2CTRL, 0, 0, STK);
         acc(1, OP_STXA, SPACE_L2CTRL, 0, 64'hFFFF_FFFF_FEFF_FFFE, NONE);
         acc(0, OP_LDXA, SPACE_L2CTRL, 0, 0, STK);
         acc(1, OP_STXA, SPACE_L2CTRL, 0, 64'h1000000, NONE);
         acc(0, OP_LDXA, SPACE_L2CTRL, 0, 0, RD0);
      end
      `CHK(stall_cnt, 0)
      lat <= 4'(2 + $urandom % 7);
      acc(1, OP_STXA, SPACE_L2CTRL, 0, 64'h1, NONE);
      `CHK(stall_cnt > lat, 1'b1)
      $display("control register test done");
      for (int r = 0; r < 2; r++) begin
         lat <= 4'($urandom);
         va = 64'($urandom) & 64'h7FFC0;
         acc(0, OP_LDXA, SPACE_TAGPROBE, va, 0, RD0);
         for (int n = 0; n < 8; n++) begin
            acc(0, OP_LDDA, SPACE_TAGRES, 64'(n) << 3, 0,
                {3'h4, (n < 7) ? {8'(8'hA0 + n), 43'h0, va[18:6]} : 64'h0});
         end
      end
      $display("tag probe test done");
      {l2_evict, l2_evict_pa} <= {1'b1, 43'($urandom)};
      @(posedge clock);
      {l2_evict, istore, istore_pa} <= {2'b01, 43'($urandom)};
      @(posedge clock);
      istore <= 1'b0;
      @(negedge clock);
      `CHK({l1i_inv, l1d_flush_inv, l1_inv_pa}, {2'b10, istore_pa})
      for (int k = 4; k < 8; k++) begin
         {l2_fill, l2_fill_state, l2_fill_pa} <= {1'b1, 3'(k), 43'($urandom)};
         @(posedge clock);
         l2_fill <= 1'b0;
         @(negedge clock);
         `CHK({l1d_excl_mod, l1d_sat_valid, l1i_allow}, (k == ST_M) ? 3'h6 : 3'h1)
      end
      $display("coherency test done");
      print_verdict();
   end
endmodule
bind chc_top chc_props #(.PA_W(PA_W), .IDX_W(IDX_W)) u_props (.*);
